//--- verilog/acsc_map.svh
// Purpose: constants for the converter control block
// Assumes: clk at 200 MHz stands in for the master clock period
// Notes:   one master clock period is one clk cycle
`ifndef ACSC_MAP_SVH
`define ACSC_MAP_SVH
`define ACSC_GPIO_NUM        4
`define ACSC_GPIO_DIR_RST    4'hF
`define ACSC_GPIO_LVL_RST    4'h0
`define ACSC_RATE_RST        3'h6
`define ACSC_INIT_CYC        18
`define ACSC_START_MIN_CYC   2
`define ACSC_HALT_LATE_CYC   16
`define ACSC_SETTLE_000      152
`define ACSC_SETTLE_001      296
`define ACSC_SETTLE_010      584
`define ACSC_SETTLE_011      1160
`define ACSC_SETTLE_100      2312
`define ACSC_SETTLE_101      4616
`define ACSC_SETTLE_110      9224
`define ACSC_CMD_RESET       8'h06
`define ACSC_CMD_START       8'h08
`define ACSC_CMD_STOP        8'h0A
`define ACSC_STARTSTOP_BIT   7
`define ACSC_BYTE_BITS       8
`endif

//--- verilog/acsc_pkg.sv
// Purpose: types for the converter control block
// Assumes: nothing
// Notes:   constants live in acsc_map.svh
package acsc_pkg;
    typedef enum logic [1:0] {
        ACSC_IDLE,
        ACSC_INIT,
        ACSC_SETTLE,
        ACSC_CONV
    } acsc_state_t;
endpackage : acsc_pkg

//--- verilog/acsc_sync.sv
// Purpose: two flip-flop synchroniser for a bus of pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   stage one is read only by stage two
`timescale 1ns/10ps
module acsc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_ff;

    // two stage capture
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_ff <= '0;
            dout  <= '0;
        end else begin
            s1_ff <= din;
            dout  <= s1_ff;
        end
    end
endmodule : acsc_sync

//--- verilog/acsc_top.sv
// Purpose: gpio, power-down, reset, conversion and serial control
// Assumes: serial clock and pins sampled by clk; clk is the master clock
// Notes:   serial data output is a pin with separate enable
`timescale 1ns/10ps
`include "acsc_map.svh"
module acsc_top (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       power_down_pin,
    input  wire logic       reset_pin_n,
    input  wire logic       start_pin,
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdo_oe,
    input  wire logic [7:0] tx_byte,
    output logic            tx_load,
    output logic [7:0]      rx_byte,
    output logic            rx_valid,
    input  wire logic [2:0] rate_select,
    input  wire logic [3:0] gpio_direction_bits,
    input  wire logic [3:0] gpio_level_bits,
    input  wire logic       gpio_level_wr,
    input  wire logic [3:0] gpio_pin_in,
    output logic [3:0]      gpio_pin_out,
    output logic [3:0]      gpio_pin_oe,
    output logic [3:0]      gpio_level_rd,
    output logic            regs_reset,
    output logic            powered_down,
    output logic            converting,
    output logic            data_ready_n
);
    logic [8:0]  sync_q;
    logic        power_down_pin_s;
    logic        rst_s;
    logic        start_s;
    logic        cs_s;
    logic        sclk_s;
    logic        sdi_s;
    logic [3:0]  gpio_s;
    logic        sclk_d_ff;
    logic        cs_d_ff;
    logic        sclk_fall;
    logic        sclk_rise;
    logic [2:0]  bit_cnt_ff;
    logic [6:0]  shift_in_ff;
    logic [7:0]  shift_out_ff;
    logic [7:0]  cur_byte;
    logic        cmd_reset;
    logic        cmd_start;
    logic        cmd_stop;
    logic        start_cmd_ff;
    logic        start_pin_d_ff;
    logic [1:0]  start_hi_ff;
    logic        run_req;
    logic        stop_req;
    logic        stop_pend_ff;
    logic        last_conv_ff;
    logic [13:0] cnt_ff;
    logic [13:0] nxt_cnt;
    logic [13:0] since_done_ff;
    logic [3:0]  gpio_dir_ff;
    logic [3:0]  gpio_lvl_ff;
    logic        in_reset;
    logic        conv_done;
    acsc_pkg::acsc_state_t state_ff;

    // pins from outside the clock domain
    acsc_sync #(.W(9)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  ({power_down_pin, reset_pin_n, start_pin, cs_n, sclk, sdi,
                gpio_pin_in[3:1]}),
        .dout (sync_q)
    );
    acsc_sync #(.W(1)) u_sync_g0 (
        .clk  (clk),
        .rstn (rstn),
        .din  (gpio_pin_in[0]),
        .dout (gpio_s[0])
    );
    assign {power_down_pin_s, rst_s, start_s, cs_s, sclk_s, sdi_s, gpio_s[3:1]} = sync_q;

    // settling length per data rate
    function automatic logic [13:0] settle_cycles(input logic [2:0] r);
        case (r)
            3'h0:    settle_cycles = 14'(`ACSC_SETTLE_000);
            3'h1:    settle_cycles = 14'(`ACSC_SETTLE_001);
            3'h2:    settle_cycles = 14'(`ACSC_SETTLE_010);
            3'h3:    settle_cycles = 14'(`ACSC_SETTLE_011);
            3'h4:    settle_cycles = 14'(`ACSC_SETTLE_100);
            3'h5:    settle_cycles = 14'(`ACSC_SETTLE_101);
            default: settle_cycles = 14'(`ACSC_SETTLE_110);
        endcase
    endfunction : settle_cycles

    // serial clock edge detection on synchronised copies
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d_ff <= 1'b0;
            cs_d_ff   <= 1'b1;
        end else begin
            sclk_d_ff <= sclk_s;
            cs_d_ff   <= cs_s;
        end
    end
    assign sclk_fall = sclk_d_ff & ~sclk_s;
    assign sclk_rise = ~sclk_d_ff & sclk_s;
    assign cur_byte  = {shift_in_ff, sdi_s};
    assign in_reset  = ~rst_s | ~power_down_pin_s;

    // byte framing and input shifter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_ff  <= 3'h0;
            shift_in_ff <= 7'h00;
        end else if (cs_s || in_reset) begin
            bit_cnt_ff  <= 3'h0;
            shift_in_ff <= 7'h00;
        end else if (sclk_fall) begin
            bit_cnt_ff  <= bit_cnt_ff + 3'h1;
            shift_in_ff <= cur_byte[6:0];
        end
    end

    // command decode: start/stop at 7th fall, reset at 8th fall
    assign cmd_start = ~cs_s & sclk_fall
                     & (bit_cnt_ff == 3'(`ACSC_STARTSTOP_BIT - 1))
                     & ({shift_in_ff[5:0], sdi_s}
                        == 7'(`ACSC_CMD_START >> 1));
    assign cmd_stop  = ~cs_s & sclk_fall
                     & (bit_cnt_ff == 3'(`ACSC_STARTSTOP_BIT - 1))
                     & ({shift_in_ff[5:0], sdi_s}
                        == 7'(`ACSC_CMD_STOP >> 1));
    assign cmd_reset = ~cs_s & sclk_fall & (bit_cnt_ff == 3'h7)
                     & (cur_byte == `ACSC_CMD_RESET);

    // received byte strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_byte  <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= ~cs_s & ~in_reset & sclk_fall
                      & (bit_cnt_ff == 3'h7);
            if (~cs_s & sclk_fall & (bit_cnt_ff == 3'h7))
                rx_byte <= cur_byte;
        end
    end

    // output shifter, loads a byte at frame start
    assign tx_load = ~cs_s & ~in_reset & sclk_rise & (bit_cnt_ff == 3'h0);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift_out_ff <= 8'h00;
            sdo          <= 1'b0;
            sdo_oe       <= 1'b0;
        end else begin
            sdo_oe <= ~cs_s & ~in_reset;
            if (cs_s) begin
                sdo <= 1'b0;
            end else if (tx_load) begin
                sdo          <= tx_byte[7];
                shift_out_ff <= {tx_byte[6:0], 1'b0};
            end else if (sclk_rise) begin
                sdo          <= shift_out_ff[7];
                shift_out_ff <= {shift_out_ff[6:0], 1'b0};
            end
        end
    end

    // start by pin held two cycles, or by command
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            start_hi_ff    <= 2'h0;
            start_pin_d_ff <= 1'b0;
            start_cmd_ff   <= 1'b0;
        end else if (in_reset || state_ff == acsc_pkg::ACSC_INIT) begin
            start_hi_ff    <= 2'h0;
            start_pin_d_ff <= 1'b0;
            start_cmd_ff   <= 1'b0;
        end else begin
            start_pin_d_ff <= start_s;
            if (!start_s)
                start_hi_ff <= 2'h0;
            else if (start_hi_ff != 2'(`ACSC_START_MIN_CYC))
                start_hi_ff <= start_hi_ff + 2'h1;
            if (cmd_start)
                start_cmd_ff <= 1'b1;
            else if (cmd_stop)
                start_cmd_ff <= 1'b0;
        end
    end
    assign run_req  = (start_hi_ff == 2'(`ACSC_START_MIN_CYC))
                    | start_cmd_ff;
    assign stop_req = cmd_stop | (start_pin_d_ff & ~start_s);

    // conversion sequencer
    assign conv_done = (state_ff == acsc_pkg::ACSC_SETTLE
                        || state_ff == acsc_pkg::ACSC_CONV)
                     && cnt_ff == 14'h0001;
    always_comb begin
        nxt_cnt = cnt_ff - 14'h0001;
        if (conv_done)
            nxt_cnt = settle_cycles(rate_select);
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= acsc_pkg::ACSC_INIT;
            cnt_ff   <= 14'(`ACSC_INIT_CYC);
        end else if (in_reset || cmd_reset) begin
            state_ff <= acsc_pkg::ACSC_INIT;
            cnt_ff   <= 14'(`ACSC_INIT_CYC);
        end else begin
            case (state_ff)
                acsc_pkg::ACSC_INIT: begin
                    cnt_ff <= cnt_ff - 14'h0001;
                    if (cnt_ff == 14'h0001)
                        state_ff <= acsc_pkg::ACSC_IDLE;
                end
                acsc_pkg::ACSC_IDLE: begin
                    if (run_req && !stop_req) begin
                        state_ff <= acsc_pkg::ACSC_SETTLE;
                        cnt_ff   <= settle_cycles(rate_select);
                    end
                end
                acsc_pkg::ACSC_SETTLE,
                acsc_pkg::ACSC_CONV: begin
                    cnt_ff <= nxt_cnt;
                    if (conv_done) begin
                        if (last_conv_ff || stop_pend_ff)
                            state_ff <= acsc_pkg::ACSC_IDLE;
                        else
                            state_ff <= acsc_pkg::ACSC_CONV;
                    end
                end
                default: state_ff <= acsc_pkg::ACSC_IDLE;
            endcase
        end
    end

    // stop placement against the last completion
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            since_done_ff <= 14'h0000;
            stop_pend_ff  <= 1'b0;
            last_conv_ff  <= 1'b0;
        end else if (in_reset || state_ff == acsc_pkg::ACSC_INIT
                     || state_ff == acsc_pkg::ACSC_IDLE) begin
            since_done_ff <= 14'h0000;
            stop_pend_ff  <= 1'b0;
            last_conv_ff  <= 1'b0;
        end else begin
            if (conv_done)
                since_done_ff <= 14'h0000;
            else if (since_done_ff != 14'h3FFF)
                since_done_ff <= since_done_ff + 14'h0001;
            if (conv_done) begin
                last_conv_ff <= stop_pend_ff;
                stop_pend_ff <= 1'b0;
            end else if (stop_req) begin
                if (since_done_ff < 14'(`ACSC_HALT_LATE_CYC)
                    && state_ff == acsc_pkg::ACSC_CONV)
                    last_conv_ff <= 1'b1;
                else
                    stop_pend_ff <= 1'b1;
            end
        end
    end

    // data ready: set wins over a same-cycle serial clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_ready_n <= 1'b1;
        end else if (in_reset || state_ff == acsc_pkg::ACSC_INIT) begin
            data_ready_n <= 1'b1;
        end else if (conv_done) begin
            data_ready_n <= 1'b0;
        end else if (sclk_fall) begin
            data_ready_n <= 1'b1;
        end else if (state_ff == acsc_pkg::ACSC_IDLE && run_req
                     && !stop_req) begin
            data_ready_n <= 1'b1;
        end
    end

    // gpio direction and level, all inputs after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gpio_dir_ff <= `ACSC_GPIO_DIR_RST;
            gpio_lvl_ff <= `ACSC_GPIO_LVL_RST;
        end else if (in_reset || state_ff == acsc_pkg::ACSC_INIT) begin
            gpio_dir_ff <= `ACSC_GPIO_DIR_RST;
            gpio_lvl_ff <= `ACSC_GPIO_LVL_RST;
        end else begin
            gpio_dir_ff <= gpio_direction_bits;
            if (gpio_level_wr)
                gpio_lvl_ff <= (gpio_lvl_ff & gpio_dir_ff)
                             | (gpio_level_bits & ~gpio_dir_ff);
        end
    end
    assign gpio_pin_out = gpio_lvl_ff;
    assign gpio_pin_oe  = ~gpio_dir_ff;

    // status outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gpio_level_rd <= 4'h0;
            regs_reset    <= 1'b1;
            powered_down  <= 1'b0;
            converting    <= 1'b0;
        end else begin
            gpio_level_rd <= gpio_s;
            regs_reset    <= state_ff == acsc_pkg::ACSC_INIT;
            powered_down  <= ~power_down_pin_s;
            converting    <= state_ff == acsc_pkg::ACSC_SETTLE
                          || state_ff == acsc_pkg::ACSC_CONV;
        end
    end
endmodule : acsc_top

//--- bench/acsc_top_asserts.sv
// Purpose: port checks for the converter control block
// Assumes: one clock domain, rstn asynchronous active low
// Notes:   pins reach the logic about two cycles late
`timescale 1ns/10ps
module acsc_top_chk (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       power_down_pin,
    input wire logic       reset_pin_n,
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       sdo_oe,
    input wire logic [3:0] gpio_direction_bits,
    input wire logic [3:0] gpio_level_bits,
    input wire logic       gpio_level_wr,
    input wire logic [3:0] gpio_pin_in,
    input wire logic [3:0] gpio_pin_out,
    input wire logic [3:0] gpio_pin_oe,
    input wire logic [3:0] gpio_level_rd,
    input wire logic       regs_reset,
    input wire logic       powered_down,
    input wire logic       converting,
    input wire logic       data_ready_n
);
    int unsigned init_cnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // length of the init phase once every reset cause is gone
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) init_cnt <= 0;
        else if (regs_reset && reset_pin_n && power_down_pin)
            init_cnt <= init_cnt + 1;
        else init_cnt <= 0;
    end
    // pin held low long enough to pass the synchroniser
    sequence s_pd_held;
        !power_down_pin [*4];
    endsequence
    sequence s_rst_held;
        !reset_pin_n [*5];
    endsequence
    // gpio, reset, ready and output enable relations
    gpio_dir_a: assert property (
        !regs_reset && !$past(regs_reset) && $stable(gpio_direction_bits)
        |-> gpio_pin_oe == ~gpio_direction_bits)
        else $error("gpio enable differs from direction");
    gpio_read_a: assert property (
        (!regs_reset && $stable(gpio_pin_in)) [*4]
        |-> gpio_level_rd == gpio_pin_in)
        else $error("gpio read differs from pin");
    wr_out_a: assert property (
        gpio_level_wr && !regs_reset |=>
        (gpio_pin_out & gpio_pin_oe) == ($past(gpio_level_bits) & gpio_pin_oe))
        else $error("gpio write not driven");
    wr_in_a: assert property (
        gpio_level_wr && !regs_reset |=>
        (gpio_pin_out & ~gpio_pin_oe) == ($past(gpio_pin_out) & ~gpio_pin_oe))
        else $error("gpio write reached an input");
    pd_enter_a: assert property (s_pd_held |-> powered_down)
        else $error("no power down");
    rst_pin_a: assert property (s_rst_held |-> regs_reset)
        else $error("reset pin ignored");
    init_len_a: assert property ($fell(regs_reset) |->
        init_cnt >= 18 && init_cnt <= 22)
        else $error("init length wrong");
    ready_gate_a: assert property ($fell(data_ready_n) |->
        $past(converting))
        else $error("ready fell while halted");
    sclk_clear_a: assert property (
        $fell(sclk) && !data_ready_n |-> ##[1:6] data_ready_n)
        else $error("serial clock did not clear ready");
    cs_float_a: assert property (cs_n [*5] |-> !sdo_oe)
        else $error("output driven while deselected");
endmodule : acsc_top_chk
bind acsc_top acsc_top_chk u_chk (.*);

//--- bench/acsc_host.sv
// Purpose: serial master standing for the host controller
// Assumes: clock idles low, device samples on the falling edge
// Notes:   clock stands still between frames, 80 ns period
`timescale 1ns/10ps
module acsc_host (
    output logic      cs_n,
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo_w
);
    logic [7:0] got;
    // idle: deselected, clock still
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
        got  = 8'h00;
    end
    // one frame of n bits, msb first; desel keeps select high
    task automatic xfer(input int n, input logic [7:0] b, input bit desel);
        #40.7;
        cs_n = desel;
        #40;
        for (int i = 0; i < n; i++) begin
            sdi  = b[7-i];
            sclk = 1'b1;
            #40;
            got  = {got[6:0], sdo_w};
            sclk = 1'b0;
            #40;
        end
        #20;
        cs_n = 1'b1;
        sdi  = ~sdi; // released line shows no stale level
    endtask : xfer
endmodule : acsc_host

//--- bench/test_adc_conversion_spi_control.sv
// Purpose: self-checking bench for the converter control block
// Assumes: host model drives the serial pins; clk is 200 MHz
// Notes:   gpio pin levels resolved from every drive enable
`timescale 1ns/10ps
`include "acsc_map.svh"
module test_adc_conversion_spi_control;
    logic       clk, rstn, power_down_pin, reset_pin_n, start_pin;
    logic       cs_n, sclk, sdi, sdo, sdo_oe, sdo_w, tx_load, rx_valid;
    logic       gpio_level_wr, regs_reset, powered_down, converting;
    logic       data_ready_n;
    logic [7:0] tx_byte, rx_byte;
    logic [2:0] rate_select;
    logic [3:0] gpio_direction_bits, gpio_level_bits, gpio_pin_in;
    logic [3:0] gpio_pin_out, gpio_pin_oe, gpio_level_rd, gpio_ext;
    int         errors, n_checks;
    int         settle[7] = '{`ACSC_SETTLE_000, `ACSC_SETTLE_001,
        `ACSC_SETTLE_010, `ACSC_SETTLE_011, `ACSC_SETTLE_100,
        `ACSC_SETTLE_101, `ACSC_SETTLE_110};
    acsc_top uut (.*);
    acsc_host host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo_w(sdo_w));
    // wire levels seen by every party
    assign gpio_pin_in = (gpio_pin_oe & gpio_pin_out)
                       | (~gpio_pin_oe & gpio_ext);
    assign sdo_w = sdo_oe ? sdo : ~sdo;
    always #2.5 clk = ~clk;
    // compare and count
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // bounded wait for ready or init to reach a level
    task automatic wait_on(input bit rr, input logic v, input int lim,
                           output int t);
        for (t = 0; (rr ? regs_reset : data_ready_n) !== v; t++) begin
            if (t == lim) begin
                chk("wait", 16'h0, 16'h1);
                end_of_test();
            end
            cyc(1);
        end
    endtask : wait_on
    // start at rate r, take first result, stop, take one trailing result, check no more follow
    task automatic run_rate(input logic [2:0] r, input bit by_pin);
        int s;
        int t;
        s = settle[r];
        rate_select = r;
        if (by_pin) begin
            start_pin = 1'b1;
            cyc(4);
        end else begin
            host.xfer(8, `ACSC_CMD_START, 1'b0);
        end
        chk("ready on start", {15'h0, data_ready_n}, 16'h1);
        wait_on(1'b0, 1'b0, s + 40, t);
        t = by_pin ? t : t + 28;
        chk("settle", {15'h0, t + 7 >= s && t <= s + 7}, 16'h1);
        if (by_pin) begin
            start_pin = 1'b0;
            host.xfer(8, 8'h00, 1'b1);
        end else begin
            host.xfer(8, `ACSC_CMD_STOP, 1'b0);
        end
        wait_on(1'b0, 1'b0, s + 20, t);
        host.xfer(8, 8'h00, by_pin);
        chk("ready cleared", {15'h0, data_ready_n}, 16'h1);
        cyc(s + 40);
        chk("halted", {15'h0, data_ready_n}, 16'h1);
        chk("not converting", {15'h0, converting}, 16'h0);
    endtask : run_rate
    // main sequence
    initial begin
        int t;
        errors = 0;
        n_checks = 0;
        clk = 1'b0;
        rstn = 1'b0;
        power_down_pin = 1'b1;
        reset_pin_n = 1'b1;
        start_pin = 1'b0;
        tx_byte = 8'hC3;
        rate_select = 3'h0;
        gpio_direction_bits = 4'h0;
        gpio_level_bits = 4'h0;
        gpio_level_wr = 1'b0;
        gpio_ext = 4'hA;
        cyc(6);
        chk("oe in reset", {12'h0, gpio_pin_oe}, 16'h0);
        chk("ready in reset", {15'h0, data_ready_n}, 16'h1);
        rstn = 1'b1;
        wait_on(1'b1, 1'b0, 40, t);
        gpio_direction_bits = 4'hF;
        cyc(6);
        chk("gpio read in", {12'h0, gpio_level_rd}, 16'hA);
        gpio_direction_bits = 4'h3;
        cyc(2);
        gpio_level_bits = 4'h5;
        gpio_level_wr = 1'b1;
        cyc(1);
        gpio_level_wr = 1'b0;
        cyc(6);
        chk("gpio oe", {12'h0, gpio_pin_oe}, 16'hC);
        chk("gpio read mix", {12'h0, gpio_level_rd}, 16'h6);
        gpio_direction_bits = 4'h0;
        cyc(6);
        chk("gpio input write", {12'h0, gpio_level_rd}, 16'h4);
        gpio_direction_bits = 4'hF;
        power_down_pin = 1'b0;
        cyc(5);
        chk("powered down", {15'h0, powered_down}, 16'h1);
        power_down_pin = 1'b1;
        cyc(4);
        wait_on(1'b1, 1'b0, 40, t);
        chk("powered up", {15'h0, powered_down}, 16'h0);
        reset_pin_n = 1'b0;
        cyc(5);
        chk("pin reset", {15'h0, regs_reset}, 16'h1);
        reset_pin_n = 1'b1;
        cyc(4);
        wait_on(1'b1, 1'b0, 40, t);
        host.xfer(3, 8'hFF, 1'b0);
        host.xfer(8, 8'h5A, 1'b0);
        cyc(3);
        chk("rx byte", {8'h0, rx_byte}, 16'h5A);
        chk("tx byte", {8'h0, host.got}, 16'hC3);
        for (int r = 0; r < 7; r++) run_rate(r[2:0], 1'b0);
        run_rate(3'h2, 1'b1);
        rate_select = 3'h0;
        host.xfer(8, `ACSC_CMD_START, 1'b0);
        host.xfer(8, `ACSC_CMD_RESET, 1'b0);
        wait_on(1'b1, 1'b1, 40, t);
        wait_on(1'b1, 1'b0, 40, t);
        cyc(settle[0] + 40);
        chk("idle after reset", {15'h0, data_ready_n}, 16'h1);
        end_of_test();
    end
endmodule : test_adc_conversion_spi_control
